// ---- logic/ubrg_top.sv ----
// Bit-rate generator: divisor and mode registers, prescaler and divisor counter
//
// Contract
// [RL1] Writing the low divisor byte (bits 7..0) restarts the bit-rate counter.
// [RL2] Writing the high divisor byte (bits 15..8) restarts the bit-rate counter.
// [RL3] High divisor byte is ignored unless the 16-bit counter select is set.
// [RL4] Divisor n is the high byte joined to the low byte.
// [RL5] Async, 8-bit, low speed: rate is clock over 64 times (n+1).
// [RL6] Async, 16-bit, low speed: rate is clock over 16 times (n+1).
// [RL7] Synchronous mode: rate is clock over 4 times (n+1), any width or speed.
// [RL8] Async high speed: 16 times (n+1) for 8-bit, 4 times (n+1) for 16-bit.
// [RL9] Width select one runs the 16-bit counter, zero the 8-bit counter.
// [RL10] Speed select means high when set, low when clear; ignored when synchronous.
// [RL11] Mode select one is synchronous operation, zero asynchronous.
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module ubrg_top (
	// Clock and reset
	input  wire logic                   clock,
	input  wire logic                   rst,
	// Register port
	input  wire ubrg_pkg::ubrg_bus_req_t bus_req,
	output logic [ubrg_pkg::DATA_W-1:0] bus_rdata,
	// Generated bit-rate
	output logic                        bit_tick,
	output logic                        sync_mode
);
	import ubrg_pkg::*;

	// Divisor actually used by the counter
	function automatic logic [DIV_W-1:0] divisor_of(input logic [7:0] high,
		input logic [7:0] low, input logic width16);
		if (width16) begin
			return {high, low}; // [RL4] [RL9]
		end
		return {8'h00, low}; // [RL3]
	endfunction

	// Oscillator cycles per divisor step
	function automatic logic [6:0] prescale_of(input ubrg_cfg_t cfg);
		if (cfg.mode_sync) begin
			return PRESCALE_SYNC; // [RL7] [RL10] [RL11]
		end
		unique case ({cfg.counter_width_select, cfg.speed_select})
			2'b00:   return PRESCALE_SLOW; // [RL5]
			2'b10:   return PRESCALE_MID; // [RL6]
			2'b01:   return PRESCALE_MID; // [RL8]
			default: return PRESCALE_SYNC; // [RL8]
		endcase
	endfunction

	logic [7:0]       divisor_low_reg;
	logic [7:0]       divisor_low_next;
	logic [7:0]       divisor_high_reg;
	logic [7:0]       divisor_high_next;
	ubrg_cfg_t        cfg_reg;
	ubrg_cfg_t        cfg_next;
	logic [7:0]       rdata_reg;
	logic [7:0]       rdata_next;
	logic [6:0]       pre_reg;
	logic [6:0]       pre_next;
	logic [DIV_W-1:0] cnt_reg;
	logic [DIV_W-1:0] cnt_next;
	logic             tick_reg;
	logic             tick_next;
	logic             wr_low;
	logic             wr_high;
	logic             wr_cfg;
	logic             restart;
	logic             tick_now;
	logic [6:0]       prescale;
	logic [DIV_W-1:0] divisor;

	assign wr_low   = bus_req.wr && (bus_req.addr == OFS_DIVISOR_LOW);
	assign wr_high  = bus_req.wr && (bus_req.addr == OFS_DIVISOR_HIGH);
	assign wr_cfg   = bus_req.wr && ((bus_req.addr == OFS_TRANSMIT_CTRL)
		|| (bus_req.addr == OFS_BIT_RATE_CTRL));
	assign restart  = wr_low || wr_high; // [RL1] [RL2]
	assign prescale = prescale_of(cfg_reg);
	assign divisor  = divisor_of(divisor_high_reg, divisor_low_reg,
		cfg_reg.counter_width_select);
	assign tick_now = (pre_reg >= (prescale - 7'h01)) && (cnt_reg == '0);

	// Register writes and read-back
	always_comb begin
		divisor_low_next  = divisor_low_reg;
		divisor_high_next = divisor_high_reg;
		cfg_next          = cfg_reg;
		rdata_next        = 8'h00;
		if (bus_req.wr) begin
			unique case (bus_req.addr)
				OFS_DIVISOR_LOW: begin
					divisor_low_next = bus_req.wdata;
				end
				OFS_DIVISOR_HIGH: begin
					divisor_high_next = bus_req.wdata;
				end
				OFS_TRANSMIT_CTRL: begin
					cfg_next.mode_sync    = bus_req.wdata[BIT_MODE_SYNC];
					cfg_next.speed_select = bus_req.wdata[BIT_SPEED_SELECT];
				end
				OFS_BIT_RATE_CTRL: begin
					cfg_next.counter_width_select = bus_req.wdata[BIT_WIDTH_SELECT];
				end
				default: begin
				end
			endcase
		end
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				OFS_DIVISOR_LOW: begin
					rdata_next = divisor_low_reg;
				end
				OFS_DIVISOR_HIGH: begin
					rdata_next = divisor_high_reg;
				end
				OFS_TRANSMIT_CTRL: begin
					rdata_next[BIT_MODE_SYNC]    = cfg_reg.mode_sync;
					rdata_next[BIT_SPEED_SELECT] = cfg_reg.speed_select;
				end
				OFS_BIT_RATE_CTRL: begin
					rdata_next[BIT_WIDTH_SELECT] = cfg_reg.counter_width_select;
				end
				OFS_COUNT_LOW: begin
					rdata_next = cnt_reg[7:0];
				end
				OFS_COUNT_HIGH: begin
					rdata_next = cnt_reg[15:8];
				end
				default: begin
					rdata_next = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			divisor_low_reg  <= RST_DIVISOR_LOW;
			divisor_high_reg <= RST_DIVISOR_HIGH;
			cfg_reg          <= '{RST_MODE_SYNC, RST_SPEED_SELECT, RST_WIDTH_SELECT};
			rdata_reg        <= 8'h00;
		end else begin
			divisor_low_reg  <= divisor_low_next;
			divisor_high_reg <= divisor_high_next;
			cfg_reg          <= cfg_next;
			rdata_reg        <= rdata_next;
		end
	end

	// Prescaler and divisor counter; period is prescale * (n + 1)
	always_comb begin
		pre_next  = pre_reg + 7'h01;
		cnt_next  = cnt_reg;
		tick_next = 1'b0;
		if (restart) begin
			pre_next = 7'h00; // [RL1] [RL2]
			cnt_next = divisor_of(divisor_high_next, divisor_low_next,
				cfg_reg.counter_width_select);
		end else if (pre_reg >= (prescale - 7'h01)) begin
			pre_next = 7'h00;
			if (cnt_reg == '0) begin
				cnt_next  = divisor; // [RL4]
				tick_next = 1'b1;
			end else begin
				cnt_next = cnt_reg - 16'h0001;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pre_reg  <= 7'h00;
			cnt_reg  <= '0;
			tick_reg <= 1'b0;
		end else begin
			pre_reg  <= pre_next;
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign bus_rdata = rdata_reg;
	assign bit_tick  = tick_reg;
	assign sync_mode = cfg_reg.mode_sync;

	// Checking helpers: cycles since last tick or restart
	function automatic logic [GAP_W-1:0] period_of(input logic [6:0] k,
		input logic [DIV_W-1:0] n);
		return GAP_W'(k) * (GAP_W'(n) + 23'h000001);
	endfunction

	logic [GAP_W-1:0] gap_reg;
	logic             gap_valid_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			gap_reg       <= 23'h000001;
			gap_valid_reg <= 1'b0;
		end else begin
			gap_reg       <= (restart || tick_now) ? 23'h000001 : gap_reg + 23'h000001;
			gap_valid_reg <= restart || (tick_now && !wr_cfg) || (gap_valid_reg && !wr_cfg);
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_low_restart;
		wr_low |=> (pre_reg == 7'h00) && (cnt_reg == divisor) && !bit_tick;
	endproperty
	a_low_restart: assert property (p_low_restart) else $error("low write no restart"); // [RL1]

	property p_high_restart;
		wr_high |=> (pre_reg == 7'h00) && (cnt_reg == divisor) && !bit_tick;
	endproperty
	a_high_restart: assert property (p_high_restart) else $error("high write no restart"); // [RL2]

	property p_high_ignored;
		!cfg_reg.counter_width_select |-> (divisor[15:8] == 8'h00);
	endproperty
	a_high_ignored: assert property (p_high_ignored) else $error("high byte used"); // [RL3]

	property p_concat;
		cfg_reg.counter_width_select |-> (divisor == {divisor_high_reg, divisor_low_reg});
	endproperty
	a_concat: assert property (p_concat) else $error("divisor not concatenated"); // [RL4]

	property p_async_8_low;
		(tick_now && gap_valid_reg && !cfg_reg.mode_sync && !cfg_reg.speed_select
			&& !cfg_reg.counter_width_select) |-> (gap_reg == period_of(PRESCALE_SLOW, divisor));
	endproperty
	a_async_8_low: assert property (p_async_8_low) else $error("bad 64x period"); // [RL5]

	property p_async_16_low;
		(tick_now && gap_valid_reg && !cfg_reg.mode_sync && !cfg_reg.speed_select
			&& cfg_reg.counter_width_select) |-> (gap_reg == period_of(PRESCALE_MID, divisor));
	endproperty
	a_async_16_low: assert property (p_async_16_low) else $error("bad 16x period"); // [RL6]

	property p_sync;
		(tick_now && gap_valid_reg && cfg_reg.mode_sync)
			|-> (gap_reg == period_of(PRESCALE_SYNC, divisor));
	endproperty
	a_sync: assert property (p_sync) else $error("bad sync period"); // [RL7]

	property p_async_high;
		(tick_now && gap_valid_reg && !cfg_reg.mode_sync && cfg_reg.speed_select)
			|-> (gap_reg == period_of(cfg_reg.counter_width_select ? PRESCALE_SYNC : PRESCALE_MID,
			divisor));
	endproperty
	a_async_high: assert property (p_async_high) else $error("bad high-speed period"); // [RL8]

	property p_width_sel;
		$rose(cfg_reg.counter_width_select) |-> (divisor[15:8] == divisor_high_reg);
	endproperty
	a_width_sel: assert property (p_width_sel) else $error("width select ignored"); // [RL9]

	property p_speed_ignored_sync;
		cfg_reg.mode_sync && $changed(cfg_reg.speed_select) |-> (prescale == PRESCALE_SYNC);
	endproperty
	a_speed_ignored_sync: assert property (p_speed_ignored_sync) else $error("speed used"); // [RL10]

	property p_mode;
		(sync_mode == cfg_reg.mode_sync) && (!cfg_reg.mode_sync || (prescale == PRESCALE_SYNC));
	endproperty
	a_mode: assert property (p_mode) else $error("mode select wrong"); // [RL11]

	property p_tick_out;
		tick_now && !restart |=> bit_tick ##1 !bit_tick;
	endproperty
	a_tick_out: assert property (p_tick_out) else $error("tick output wrong");

	c_restart_tick: cover property (restart ##[1:300] bit_tick);
	c_sync_tick: cover property (cfg_reg.mode_sync && tick_now && gap_valid_reg);
	c_wide_high: cover property (cfg_reg.counter_width_select && tick_now
		&& divisor[15:8] != 8'h00);

endmodule // ubrg_top

`default_nettype wire

// ---- logic/ubrg_pkg.sv ----
// Package: register map, field positions and constants of the bit-rate generator
package ubrg_pkg;

	localparam int          ADDR_W             = 3;
	localparam int          DATA_W             = 8;
	localparam int          DIV_W              = 16;
	localparam int          GAP_W              = 23;

	// Register offsets
	localparam logic [2:0]  OFS_DIVISOR_LOW    = 3'h0;
	localparam logic [2:0]  OFS_DIVISOR_HIGH   = 3'h1;
	localparam logic [2:0]  OFS_TRANSMIT_CTRL  = 3'h2;
	localparam logic [2:0]  OFS_BIT_RATE_CTRL  = 3'h3;
	localparam logic [2:0]  OFS_COUNT_LOW      = 3'h4;
	localparam logic [2:0]  OFS_COUNT_HIGH     = 3'h5;

	// Field positions
	localparam int          BIT_MODE_SYNC      = 4;
	localparam int          BIT_SPEED_SELECT   = 2;
	localparam int          BIT_WIDTH_SELECT   = 3;

	// Reset values
	localparam logic [7:0]  RST_DIVISOR_LOW    = 8'h00;
	localparam logic [7:0]  RST_DIVISOR_HIGH   = 8'h00;
	localparam logic        RST_MODE_SYNC      = 1'b0;
	localparam logic        RST_SPEED_SELECT   = 1'b0;
	localparam logic        RST_WIDTH_SELECT   = 1'b0;

	// Oscillator cycles per divisor step
	localparam logic [6:0]  PRESCALE_SYNC      = 7'h04;
	localparam logic [6:0]  PRESCALE_MID       = 7'h10;
	localparam logic [6:0]  PRESCALE_SLOW      = 7'h40;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} ubrg_bus_req_t;

	typedef struct packed {
		logic mode_sync;
		logic speed_select;
		logic counter_width_select;
	} ubrg_cfg_t;

endpackage

// ---- bench/ubrg_top_tb.sv ----
// Self-checking bench of the bit-rate generator
`timescale 1ns/10ps
`default_nettype none

module ubrg_top_tb;
	import ubrg_pkg::*;

	typedef struct packed {
		logic        sync;
		logic        wide;
		logic        fast;
		logic [7:0]  lo;
		logic [7:0]  hi;
		logic [15:0] per;
	} ubrg_row_t;

	logic              clock;
	logic              rst;
	ubrg_bus_req_t     bus_req;
	logic [DATA_W-1:0] bus_rdata;
	logic              bit_tick;
	logic              sync_mode;
	int                bad_count;
	int                num_checks;
	int                t;
	ubrg_row_t         rows [7];

	ubrg_top dut (
		.clock     (clock),
		.rst       (rst),
		.bus_req   (bus_req),
		.bus_rdata (bus_rdata),
		.bit_tick  (bit_tick),
		.sync_mode (sync_mode)
	);

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic give_verdict();
		if (bad_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus_req.wr <= 1'b0;
	endtask

	// Data checked in the cycle after the strobe, then must fall to zero
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clock);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus_req.rd <= 1'b0;
		#1;
		chk({8'h00, bus_rdata}, {8'h00, exp}, "read data");
		@(posedge clock);
		#1;
		chk({8'h00, bus_rdata}, 16'h0000, "read data after");
	endtask

	// Counts edges until the next tick; a stuck-high tick gives a count of one
	task automatic wait_tick(input logic [15:0] exp, input string what);
		t = 0;
		do begin
			@(posedge clock);
			#1;
			t++;
		end while (bit_tick !== 1'b1 && t <= exp + 2);
		chk(t[15:0], exp, what);
		if (bit_tick !== 1'b1) give_verdict();
	endtask

	initial begin
		rst        = 1'b1;
		bus_req    = '0;
		bad_count  = 0;
		num_checks = 0;
		rows[0] = '{1'b0, 1'b0, 1'b0, 8'h02, 8'h05, 16'h00C0};
		rows[1] = '{1'b0, 1'b1, 1'b0, 8'h03, 8'h01, 16'h1040};
		rows[2] = '{1'b0, 1'b0, 1'b1, 8'h04, 8'h00, 16'h0050};
		rows[3] = '{1'b0, 1'b1, 1'b1, 8'h01, 8'h02, 16'h0808};
		rows[4] = '{1'b1, 1'b0, 1'b0, 8'h00, 8'h07, 16'h0004};
		rows[5] = '{1'b1, 1'b1, 1'b1, 8'h02, 8'h01, 16'h040C};
		rows[6] = '{1'b1, 1'b0, 1'b1, 8'h09, 8'h00, 16'h0028};
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		#1;
		chk({15'h0, sync_mode}, 16'h0000, "mode after reset");
		rd(OFS_DIVISOR_LOW, 8'h00);
		rd(OFS_DIVISOR_HIGH, 8'h00);
		foreach (rows[i]) begin
			wr(OFS_TRANSMIT_CTRL, {3'h0, rows[i].sync, 1'b0, rows[i].fast, 2'h0});
			wr(OFS_BIT_RATE_CTRL, {4'h0, rows[i].wide, 3'h0});
			wr(OFS_DIVISOR_HIGH, rows[i].hi);
			wr(OFS_DIVISOR_LOW, rows[i].lo);
			wait_tick(rows[i].per, "first tick");
			wait_tick(rows[i].per, "tick period");
			chk({15'h0, sync_mode}, {15'h0, rows[i].sync}, "mode");
			rd(OFS_DIVISOR_LOW, rows[i].lo);
			rd(OFS_DIVISOR_HIGH, rows[i].hi);
			rd(OFS_TRANSMIT_CTRL, {3'h0, rows[i].sync, 1'b0, rows[i].fast, 2'h0});
			rd(OFS_BIT_RATE_CTRL, {4'h0, rows[i].wide, 3'h0});
		end
		// Restart in mid-count; high byte ignored with the 8-bit counter
		repeat (20) @(posedge clock);
		wr(OFS_DIVISOR_HIGH, 8'h03);
		wait_tick(16'h0028, "restart by high byte");
		wait_tick(16'h0028, "period after restart");
		// Counter reloaded with n at the tick, high byte still ignored
		rd(OFS_COUNT_LOW, 8'h09);
		rd(OFS_COUNT_HIGH, 8'h00);
		// Unmapped place neither stores nor disturbs the divisor
		wr(3'h6, 8'hFF);
		rd(3'h6, 8'h00);
		rd(OFS_DIVISOR_LOW, 8'h09);
		// Second reset in mid-run
		@(posedge clock);
		rst <= 1'b1;
		@(posedge clock);
		rst <= 1'b0;
		#1;
		chk({15'h0, sync_mode}, 16'h0000, "mode after second reset");
		rd(OFS_DIVISOR_LOW, 8'h00);
		rd(OFS_DIVISOR_HIGH, 8'h00);
		give_verdict();
	end

endmodule // ubrg_top_tb

`default_nettype wire
